// >>> shared/flash_prog_pkg.sv
// constants and types for the serial flash program sequencer
package flash_prog_pkg;
  // command opcodes
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_SEQ_PROGRAM_A = 8'had;
  localparam logic [7:0] OP_SEQ_PROGRAM_B = 8'haf;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  // array geometry
  localparam int ADDR_W = 20;
  localparam int PAGE_BYTES = 256;
  localparam int SECTOR_LSB = 16;
  localparam int NUM_SECTORS = 16;
  localparam logic [19:0] ADDR_LAST = 20'hfffff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // framing: opcode plus three address bytes
  localparam logic [2:0] HDR_BYTES = 3'h4;
  // self-timed program durations
  localparam int CLK_PERIOD_NS = 10;
  localparam int PAGE_PROGRAM_TIME_NS = 1000000;
  localparam int BYTE_PROGRAM_TIME_NS = 50000;
  localparam int PAGE_PROGRAM_CYCLES = PAGE_PROGRAM_TIME_NS / CLK_PERIOD_NS;
  localparam int BYTE_PROGRAM_CYCLES = BYTE_PROGRAM_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 24;
  // reset values
  localparam logic RST_WEL = 1'b0;
  localparam logic RST_SEQ = 1'b0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PAGE = 2'b01,
    ST_WAIT = 2'b10
  } state_t;
endpackage

// >>> logic/flash_prog_seq.sv
// page program and sequential program sequencer behind the serial pins
`timescale 1ns/100ps
module flash_prog_seq
  import flash_prog_pkg::*;
#(
  parameter int PAGE_CYCLES = PAGE_PROGRAM_CYCLES,
  parameter int BYTE_CYCLES = BYTE_PROGRAM_CYCLES
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // serial pins
  input wire logic spi_cs_n_i,
  input wire logic spi_sck_i,
  input wire logic spi_si_i,
  // sector protection and array result
  input wire logic [NUM_SECTORS-1:0] prot_map_i,
  input wire logic mem_fail_i,
  // array write port
  output logic mem_wr_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  // status
  output logic busy_o,
  output logic write_enable_latch_o,
  output logic program_erase_error_flag_o,
  output logic seq_mode_o
);

  if (PAGE_CYCLES < 1 || PAGE_CYCLES >= 2 ** CNT_W) begin : g_chk_page
    $error("PAGE_CYCLES out of range");
  end
  if (BYTE_CYCLES < 1 || BYTE_CYCLES >= 2 ** CNT_W) begin : g_chk_byte
    $error("BYTE_CYCLES out of range");
  end

  localparam logic [CNT_W-1:0] PAGE_LOAD = CNT_W'(PAGE_CYCLES - 1);
  localparam logic [CNT_W-1:0] BYTE_LOAD = CNT_W'(BYTE_CYCLES - 1);

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic si_s1;
    logic si_s2;
    logic [7:0] shift;
    logic [2:0] bitcnt;
    logic [2:0] nbyte;
    logic got_data;
    logic op_ok;
    logic [7:0] opcode;
    logic [ADDR_W-1:0] addr;
    logic [7:0] dcnt;
    logic [PAGE_BYTES-1:0][7:0] pbuf;
    logic [PAGE_BYTES-1:0] vld;
    logic [7:0] seq_byte;
    logic [ADDR_W-1:0] seq_addr;
    logic write_enable_latch;
    logic seq;
    logic busy;
    logic err;
    state_t state;
    logic [7:0] idx;
    logic [CNT_W-1:0] cnt;
    logic mem_wr;
    logic [ADDR_W-1:0] mem_addr;
    logic [7:0] mem_wdata;
  } seq_state_t;

  seq_state_t r_reg;
  seq_state_t r_next;

  logic sck_rise;
  logic cs_rise;
  logic cs_fall;
  logic [7:0] rx_byte;
  logic is_seq_op;
  logic aligned;
  logic frame_ok;
  logic [ADDR_W-1:0] next_addr;

  // only the second and third stages feed edge detection
  assign sck_rise = r_reg.sck_s2 && !r_reg.sck_s3 && !r_reg.cs_s2;
  assign cs_rise = r_reg.cs_s2 && !r_reg.cs_s3;
  assign cs_fall = !r_reg.cs_s2 && r_reg.cs_s3;
  assign rx_byte = {r_reg.shift[6:0], r_reg.si_s2};
  assign is_seq_op = (r_reg.opcode == OP_SEQ_PROGRAM_A) || (r_reg.opcode == OP_SEQ_PROGRAM_B);
  assign aligned = (r_reg.bitcnt == 3'h0);
  assign frame_ok = (r_reg.nbyte == HDR_BYTES) && r_reg.got_data && aligned;
  assign next_addr = r_reg.seq_addr + 20'h00001;

  always_comb begin
    r_next = r_reg;
    r_next.cs_s1 = spi_cs_n_i;
    r_next.cs_s2 = r_reg.cs_s1;
    r_next.cs_s3 = r_reg.cs_s2;
    r_next.sck_s1 = spi_sck_i;
    r_next.sck_s2 = r_reg.sck_s1;
    r_next.sck_s3 = r_reg.sck_s2;
    r_next.si_s1 = spi_si_i;
    r_next.si_s2 = r_reg.si_s1;
    r_next.mem_wr = 1'b0;

    // new frame: byte framing restarts
    if (cs_fall) begin
      r_next.bitcnt = 3'h0;
      r_next.nbyte = 3'h0;
      r_next.got_data = 1'b0;
      r_next.op_ok = 1'b0;
      r_next.dcnt = 8'h00;
    end

    // msb first shift on each rising serial clock
    if (sck_rise) begin
      r_next.shift = rx_byte;
      r_next.bitcnt = r_reg.bitcnt + 3'h1;
      if (r_reg.bitcnt == 3'h7) begin
        if (r_reg.nbyte == 3'h0) begin
          r_next.opcode = rx_byte;
          r_next.nbyte = 3'h1;
          // data capture is refused while busy so the buffer stays stable
          if (!r_reg.busy) begin
            if (rx_byte == OP_PAGE_PROGRAM && r_reg.write_enable_latch) begin
              r_next.op_ok = 1'b1;
              r_next.vld = '0;
            end else if ((rx_byte == OP_SEQ_PROGRAM_A || rx_byte == OP_SEQ_PROGRAM_B)
                         && (r_reg.seq || r_reg.write_enable_latch)) begin
              r_next.op_ok = 1'b1;
              if (r_reg.seq) begin
                r_next.nbyte = HDR_BYTES;
              end
            end
          end
        end else if (r_reg.nbyte < HDR_BYTES) begin
          r_next.nbyte = r_reg.nbyte + 3'h1;
          if (r_reg.op_ok) begin
            r_next.addr = {r_reg.addr[ADDR_W-9:0], rx_byte};
          end
        end else begin
          r_next.got_data = 1'b1;
          if (r_reg.op_ok && r_reg.opcode == OP_PAGE_PROGRAM) begin
            // index wraps inside the page; later bytes overwrite earlier ones
            r_next.pbuf[r_reg.addr[7:0] + r_reg.dcnt] = rx_byte;
            r_next.vld[r_reg.addr[7:0] + r_reg.dcnt] = 1'b1;
            r_next.dcnt = r_reg.dcnt + 8'h01;
          end else if (r_reg.op_ok) begin
            r_next.seq_byte = rx_byte;
          end
        end
      end
    end

    // end of frame decides what runs
    if (cs_rise && !r_reg.busy) begin
      if (r_reg.nbyte != 3'h0 && aligned && r_reg.opcode == OP_WRITE_ENABLE) begin
        r_next.write_enable_latch = 1'b1;
      end else if (r_reg.nbyte != 3'h0 && aligned && r_reg.opcode == OP_WRITE_DISABLE) begin
        r_next.write_enable_latch = 1'b0;
        r_next.seq = 1'b0;
      end else if (r_reg.op_ok && r_reg.opcode == OP_PAGE_PROGRAM) begin
        r_next.write_enable_latch = 1'b0;
        // without the latch sequential mode is unusable, so it ends here too
        r_next.seq = 1'b0;
        if (frame_ok && !prot_map_i[r_reg.addr[ADDR_W-1:SECTOR_LSB]]) begin
          r_next.busy = 1'b1;
          r_next.err = 1'b0;
          r_next.state = ST_PAGE;
          r_next.idx = 8'h00;
        end
      end else if (r_reg.op_ok && is_seq_op && !r_reg.seq) begin
        if (frame_ok && !prot_map_i[r_reg.addr[ADDR_W-1:SECTOR_LSB]]) begin
          r_next.busy = 1'b1;
          r_next.err = 1'b0;
          r_next.seq = 1'b1;
          r_next.seq_addr = r_reg.addr;
          r_next.mem_wr = 1'b1;
          r_next.mem_addr = r_reg.addr;
          r_next.mem_wdata = r_reg.seq_byte;
          r_next.state = ST_WAIT;
          r_next.cnt = BYTE_LOAD;
        end else begin
          r_next.write_enable_latch = 1'b0;
        end
      end else if (r_reg.op_ok && is_seq_op) begin
        if (r_reg.got_data && aligned) begin
          r_next.busy = 1'b1;
          r_next.err = 1'b0;
          r_next.mem_wr = 1'b1;
          r_next.mem_addr = r_reg.seq_addr;
          r_next.mem_wdata = r_reg.seq_byte;
          r_next.state = ST_WAIT;
          r_next.cnt = BYTE_LOAD;
        end else begin
          r_next.write_enable_latch = 1'b0;
          r_next.seq = 1'b0;
        end
      end
    end

    // the array reports a failed byte while the cycle runs
    if (r_reg.busy && mem_fail_i) begin
      r_next.err = 1'b1;
    end

    case (r_reg.state)
      ST_IDLE: begin
      end
      ST_PAGE: begin
        // only bytes that received data are written; the rest stay as they are
        if (r_reg.vld[r_reg.idx]) begin
          r_next.mem_wr = 1'b1;
          r_next.mem_addr = {r_reg.addr[ADDR_W-1:8], r_reg.idx};
          r_next.mem_wdata = r_reg.pbuf[r_reg.idx];
        end
        r_next.idx = r_reg.idx + 8'h01;
        if (r_reg.idx == 8'hff) begin
          r_next.state = ST_WAIT;
          r_next.cnt = PAGE_LOAD;
        end
      end
      ST_WAIT: begin
        r_next.cnt = r_reg.cnt - CNT_W'(1);
        if (r_reg.cnt == '0) begin
          r_next.busy = 1'b0;
          r_next.state = ST_IDLE;
          if (r_reg.seq) begin
            if (r_reg.seq_addr == ADDR_LAST) begin
              r_next.seq = 1'b0;
              r_next.write_enable_latch = 1'b0;
            end else if (prot_map_i[next_addr[ADDR_W-1:SECTOR_LSB]]) begin
              r_next.seq = 1'b0;
              r_next.write_enable_latch = 1'b0;
            end else begin
              r_next.seq_addr = next_addr;
            end
          end
        end
      end
      default: begin
        r_next.state = ST_IDLE;
        r_next.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r_reg <= '0;
      r_reg.cs_s1 <= 1'b1;
      r_reg.cs_s2 <= 1'b1;
      r_reg.cs_s3 <= 1'b1;
      r_reg.write_enable_latch <= RST_WEL;
      r_reg.seq <= RST_SEQ;
      r_reg.state <= ST_IDLE;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  assign mem_wr_o = r_reg.mem_wr;
  assign mem_addr_o = r_reg.mem_addr;
  assign mem_wdata_o = r_reg.mem_wdata;
  assign busy_o = r_reg.busy;
  assign write_enable_latch_o = r_reg.write_enable_latch;
  assign program_erase_error_flag_o = r_reg.err;
  assign seq_mode_o = r_reg.seq;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  start_needs_wel_a: assert property ($rose(busy_o) |-> $past(write_enable_latch_o))
    else $error("program started without write enable");

  page_wel_clr_a: assert property ($rose(busy_o) && !seq_mode_o |-> !write_enable_latch_o)
    else $error("latch still set during page program");

  seq_has_wel_a: assert property (seq_mode_o |-> write_enable_latch_o)
    else $error("sequential mode without write latch");

  write_when_busy_a: assert property (mem_wr_o |-> busy_o)
    else $error("array write outside a program cycle");

  page_wrap_a: assert property (
    mem_wr_o && r_reg.state == ST_PAGE |-> mem_addr_o[19:8] == r_reg.addr[19:8])
    else $error("page write left its page");

  misaligned_abort_a: assert property (
    cs_rise && !aligned && !busy_o && ce_i |=> !busy_o ##1 !busy_o)
    else $error("program started on misaligned frame");

  wel_set_a: assert property (
    cs_rise && !busy_o && ce_i && aligned && r_reg.nbyte != 3'h0
    && r_reg.opcode == OP_WRITE_ENABLE |=> write_enable_latch_o)
    else $error("write enable did not set latch");

  wdis_exit_a: assert property (
    cs_rise && !busy_o && ce_i && aligned && r_reg.nbyte != 3'h0
    && r_reg.opcode == OP_WRITE_DISABLE |=> !seq_mode_o && !write_enable_latch_o)
    else $error("write disable left the mode active");

  seq_end_a: assert property (
    $fell(busy_o) && $past(seq_mode_o) && mem_addr_o == ADDR_LAST
    |-> !seq_mode_o && !write_enable_latch_o)
    else $error("sequential mode kept past last byte");

  fail_flag_a: assert property (busy_o && mem_fail_i && ce_i |=> program_erase_error_flag_o)
    else $error("failed byte not flagged");

  seq_advance_a: assert property (
    $fell(busy_o) && seq_mode_o |-> r_reg.seq_addr == $past(r_reg.seq_addr) + 20'h00001)
    else $error("sequential address did not advance");

endmodule

// >>> dv/spi_host.sv
// serial host model driving chip select, clock and data in mode 0 or 3
`timescale 1ns/100ps
module spi_host (
  // clock
  input wire logic clk_sys_i,
  // serial pins
  output logic spi_cs_n_o,
  output logic spi_sck_o,
  output logic spi_si_o
);
  logic [7:0] tx_q[$];
  // serial clock idle level: low for mode 0, high for mode 3
  logic cpol = 1'b0;
  initial begin
    spi_cs_n_o = 1'b1;
    spi_sck_o = 1'b0;
    spi_si_o = 1'b0;
  end
  // 160 ns serial period: 8 system clocks per half
  task automatic half();
    repeat (8) @(posedge clk_sys_i);
  endtask
  // whole bytes msb first, then extra bits that break byte alignment
  task automatic frame(input int extra);
    logic [7:0] b;
    int n;
    // idle level settles while chip select is still high
    spi_sck_o <= cpol;
    half();
    spi_cs_n_o <= 1'b0;
    half();
    while (tx_q.size() > 0 || extra > 0) begin
      n = 8;
      b = 8'ha5;
      if (tx_q.size() > 0) begin
        b = tx_q.pop_front();
      end else begin
        n = extra;
        extra = 0;
      end
      for (int i = 7; i > 7 - n; i--) begin
        spi_sck_o <= 1'b0;
        spi_si_o <= b[i];
        half();
        spi_sck_o <= 1'b1;
        half();
      end
    end
    spi_sck_o <= cpol;
    half();
    spi_cs_n_o <= 1'b1;
    // released line must not keep showing the last bit
    spi_si_o <= ~spi_si_o;
    half();
  endtask
endmodule

// >>> dv/tb_top.sv
// self-checking bench for the flash program sequencer
`timescale 1ns/100ps
module tb_top;
  import flash_prog_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic ce_i = 1'b1;
  logic [NUM_SECTORS-1:0] prot_map_i;
  logic mem_fail_i;
  logic cs_n, sck, si;
  logic mem_wr_o, busy_o, write_enable_latch_o, program_erase_error_flag_o, seq_mode_o;
  logic [ADDR_W-1:0] mem_addr_o, sa;
  logic [7:0] mem_wdata_o, d;
  logic busy_seen;
  int busy_cyc;
  logic [ADDR_W-1:0] wa_q[$];
  logic [7:0] wd_q[$];
  int failures = 0;
  int checked = 0;
  int seed = 46481;
  localparam int PAGE_T = 20;
  localparam int BYTE_T = 5;
  always #5 clk_sys_i = ~clk_sys_i;
  spi_host host (.clk_sys_i(clk_sys_i), .spi_cs_n_o(cs_n), .spi_sck_o(sck), .spi_si_o(si));
  // short program times keep the run small
  flash_prog_seq #(.PAGE_CYCLES(PAGE_T), .BYTE_CYCLES(BYTE_T)) dut (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .spi_cs_n_i(cs_n), .spi_sck_i(sck), .spi_si_i(si),
    .prot_map_i(prot_map_i), .mem_fail_i(mem_fail_i),
    .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .busy_o(busy_o), .write_enable_latch_o(write_enable_latch_o),
    .program_erase_error_flag_o(program_erase_error_flag_o), .seq_mode_o(seq_mode_o));
  // enable drops at random while busy; all state must hold meanwhile
  always @(posedge clk_sys_i) begin
    ce_i <= !(busy_o === 1'b1 && ({$random(seed)} % 4) == 0);
    if (busy_o === 1'b1 && ce_i === 1'b1) begin
      busy_seen <= 1'b1;
      busy_cyc <= busy_cyc + 1;
    end
    // a frozen strobe stands several edges but is one write
    if (mem_wr_o === 1'b1 && ce_i === 1'b1) begin
      wa_q.push_back(mem_addr_o);
      wd_q.push_back(mem_wdata_o);
    end
  end
  task automatic close_out();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk_f(input logic got, input logic exp, input string m);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic chk_w(input logic [ADDR_W-1:0] a, input logic [7:0] v, input string m);
    logic [ADDR_W-1:0] ga;
    logic [7:0] gd;
    ga = 'x;
    gd = 'x;
    if (wa_q.size() > 0) begin
      ga = wa_q.pop_front();
      gd = wd_q.pop_front();
    end
    chk_f({ga, gd} === {a, v}, 1'b1, m);
  endtask
  // buffer slot wraps inside the page
  function automatic logic [7:0] pidx(input logic [ADDR_W-1:0] a, input int i);
    return a[7:0] + 8'(i);
  endfunction
  task automatic send(input logic [7:0] q[$], input int extra);
    wa_q.delete();
    wd_q.delete();
    busy_seen = 1'b0;
    busy_cyc = 0;
    host.tx_q = q;
    host.frame(extra);
    for (int i = 0; i < 1000 && busy_o !== 1'b0; i++)
      @(posedge clk_sys_i);
    chk_f(busy_o, 1'b0, "busy stuck");
  endtask
  task automatic wen();
    send('{OP_WRITE_ENABLE}, 0);
    chk_f(write_enable_latch_o, 1'b1, "latch set");
  endtask
  task automatic page(input logic [ADDR_W-1:0] a, input int n);
    logic [7:0] q[$];
    logic [7:0] ex[256];
    bit hit[256];
    logic [7:0] v;
    q = '{OP_PAGE_PROGRAM, {4'ha, a[19:16]}, a[15:8], a[7:0]};
    for (int i = 0; i < n; i++) begin
      v = 8'($random(seed));
      q.push_back(v);
      ex[pidx(a, i)] = v;
      hit[pidx(a, i)] = 1'b1;
    end
    wen();
    send(q, 0);
    chk_f(busy_seen, 1'b1, "page busy");
    chk_f(busy_cyc == 256 + PAGE_T, 1'b1, "page time");
    chk_f(write_enable_latch_o, 1'b0, "page latch");
    for (int k = 0; k < 256; k++)
      if (hit[k])
        chk_w({a[19:8], 8'(k)}, ex[k], "page byte");
    chk_f(wa_q.size() == 0, 1'b1, "page extra writes");
  endtask
  task automatic abort(input logic [7:0] q[$], input int extra);
    wen();
    send(q, extra);
    chk_f(busy_seen === 1'b0 && wa_q.size() == 0, 1'b1, "abort ran");
    chk_f(write_enable_latch_o, 1'b0, "abort latch");
  endtask
  task automatic sq_end(input logic [ADDR_W-1:0] a, input logic wr, input string m);
    wen();
    send('{OP_SEQ_PROGRAM_A, {4'hc, a[19:16]}, a[15:8], a[7:0], 8'h5a}, 0);
    if (wr)
      chk_w(a, 8'h5a, m);
    chk_f(seq_mode_o | write_enable_latch_o, 1'b0, m);
    chk_f(wa_q.size() == 0, 1'b1, m);
  endtask
  initial begin
    prot_map_i = '0;
    mem_fail_i = 1'b0;
    repeat (8) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk_f(seq_mode_o | write_enable_latch_o | busy_o, 1'b0, "after reset");
    $display("test reset done");
    send('{OP_PAGE_PROGRAM, 8'h00, 8'h01, 8'h00, 8'h5a}, 0);
    chk_f(busy_seen === 1'b0 && wa_q.size() == 0, 1'b1, "page without latch");
    page(20'h3_45fe, 3);
    page({4'h7, 16'($random(seed))}, 258);
    mem_fail_i <= 1'b1;
    page(20'h5_0000, 1);
    chk_f(program_erase_error_flag_o, 1'b1, "error flag");
    mem_fail_i <= 1'b0;
    page(20'h5_0100, 1);
    chk_f(program_erase_error_flag_o, 1'b0, "error cleared");
    $display("test page done");
    // remaining frames idle the serial clock high
    host.cpol = 1'b1;
    abort('{OP_PAGE_PROGRAM, 8'h00, 8'h10}, 0);
    abort('{OP_PAGE_PROGRAM, 8'h00, 8'h10, 8'h00}, 0);
    abort('{OP_PAGE_PROGRAM, 8'h00, 8'h10, 8'h00, 8'h33}, 3);
    prot_map_i <= 16'h0004;
    abort('{OP_PAGE_PROGRAM, 8'h02, 8'h10, 8'h00, 8'h33}, 0);
    $display("test abort done");
    send('{OP_SEQ_PROGRAM_A, 8'h01, 8'h00, 8'h00, 8'h11}, 0);
    chk_f(seq_mode_o === 1'b0 && wa_q.size() == 0, 1'b1, "seq without latch");
    sa = {8'h10, 12'($random(seed))};
    d = 8'($random(seed));
    wen();
    send('{OP_SEQ_PROGRAM_A, {4'h0, sa[19:16]}, sa[15:8], sa[7:0], ~d, d}, 0);
    chk_f(seq_mode_o, 1'b1, "seq entry");
    chk_w(sa, d, "seq first byte");
    send('{OP_SEQ_PROGRAM_B, ~d}, 0);
    chk_w(sa + 20'h1, ~d, "seq next byte");
    chk_f(write_enable_latch_o, 1'b1, "seq latch kept");
    send('{OP_WRITE_DISABLE}, 0);
    chk_f(seq_mode_o | write_enable_latch_o, 1'b0, "seq exit");
    sa = sa + 20'h2;
    wen();
    send('{OP_SEQ_PROGRAM_A, {4'h0, sa[19:16]}, sa[15:8], sa[7:0], d}, 0);
    chk_w(sa, d, "seq re-entry byte");
    chk_f(seq_mode_o === 1'b1 && busy_cyc == BYTE_T, 1'b1, "seq time");
    // reset in the middle of sequential mode
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk_f(seq_mode_o | write_enable_latch_o | busy_o, 1'b0, "mid reset");
    wen();
    send('{OP_SEQ_PROGRAM_B, 8'h01, 8'h00, 8'h00, d}, 1 + ({$random(seed)} % 7));
    chk_f(seq_mode_o | write_enable_latch_o, 1'b0, "seq abort");
    chk_f(wa_q.size() == 0, 1'b1, "seq abort write");
    sq_end(ADDR_LAST, 1'b1, "seq array end");
    sq_end(20'h1_ffff, 1'b1, "seq before guard");
    sq_end(20'h2_0010, 1'b0, "seq guarded start");
    $display("test sequential done");
    close_out();
  end
  initial begin
    repeat (80000) @(posedge clk_sys_i);
    failures++;
    close_out();
  end
endmodule
